// file: hw/sanc_pkg.sv
// Shared constants and carriers of the serial-port negotiation register bank
package sanc_pkg;

	// ==========================================
	// Widths
	localparam int SANC_AW = 21;
	localparam int SANC_DW = 16;
	localparam int SANC_CTRL_W = 5;
	localparam int SANC_IRQ_W = 2;

	// ==========================================
	// Register offsets
	localparam logic [20:0] SANC_CTRL_OFS = 21'h1f_8001;
	localparam logic [20:0] SANC_STAT_OFS = 21'h1f_8002;
	localparam logic [20:0] SANC_ADV_OFS = 21'h1f_0004;
	localparam logic [20:0] SANC_ISTAT_OFS = 21'h1f_8010;
	localparam logic [20:0] SANC_IMASK_OFS = 21'h1f_8011;

	// ==========================================
	// Control fields
	localparam int SANC_CTRL_LINKCFG_BIT = 4;
	localparam int SANC_CTRL_ROLE_BIT = 3;
	localparam int SANC_CTRL_MODE_HI = 2;
	localparam int SANC_CTRL_MODE_LO = 1;
	localparam int SANC_CTRL_IEN_BIT = 0;
	localparam logic [4:0] SANC_CTRL_RST = 5'h04;

	// ==========================================
	// Result status fields
	localparam int SANC_STAT_LINK_BIT = 4;
	localparam int SANC_STAT_SPD_HI = 3;
	localparam int SANC_STAT_SPD_LO = 2;
	localparam int SANC_STAT_FDX_BIT = 1;
	localparam int SANC_STAT_DONE_BIT = 0;
	localparam logic [1:0] SANC_SPD_RST = 2'h0;
	localparam logic [1:0] SANC_SPD_RSVD = 2'h3;

	// ==========================================
	// Event status and mask fields
	localparam int SANC_IRQ_LINK_BIT = 0;
	localparam int SANC_IRQ_SPD_BIT = 1;
	localparam logic [1:0] SANC_IRQ_RST = 2'h0;
	localparam logic [15:0] SANC_RD_ZERO = 16'h0000;

	typedef enum logic [1:0]
	{
		SANC_MODE_SERDES = 2'h0,
		SANC_MODE_SGMII = 2'h2
	} sanc_mode_e;

	typedef struct packed
	{
		logic [20:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} sanc_bus_req_s;

	typedef struct packed
	{
		logic done;
		logic link;
		logic [1:0] speed;
		logic full_dx;
	} sanc_partner_s;

	typedef struct packed
	{
		logic link_cfg;
		logic phy_side;
		logic [1:0] mode;
		logic irq_en;
	} sanc_cfg_s;

endpackage : sanc_pkg

// file: hw/sanc_regs.sv
// Negotiation control and result status registers of the serial gigabit port
// What this block does
// - Control writes wait in a shadow until the advertisement register is written.
// - Role bit: zero is MAC-side slave, one is PHY-side master.
// - Mode field: 00 SerDes, 10 SGMII and reset value, others reserved.
// - Enable bit lets negotiation completion drive the interrupt output.
// - Status link bit shows the partner's announced link state.
// - Status speed field shows the partner's announced speed code.
// - Status duplex bit shows the partner's announced duplex.
// - Completion flag sets on finish and stays until software writes zero.
// - Completion flag behaves the same whatever the enable bit says.
// - In SerDes mode each completion clears the status link, speed and duplex fields; until then they keep their old values.
`timescale 1ns/1ps
`default_nettype none

module sanc_regs
	import sanc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	input wire sanc_bus_req_s bus_i,
	output logic [SANC_DW-1:0] rdata_o,
	input wire sanc_partner_s partner_i,
	output sanc_cfg_s cfg_o,
	output logic irq_o
);

	// ==========================================
	// Decode
	logic wr_ctrl;
	logic wr_stat;
	logic wr_adv;
	logic wr_istat;
	logic wr_imask;
	logic done_clr;
	logic sgmii_appl;
	logic an_evt;

	assign wr_ctrl = ce && bus_i.wr && (bus_i.addr == SANC_CTRL_OFS);
	assign wr_stat = ce && bus_i.wr && (bus_i.addr == SANC_STAT_OFS);
	assign wr_adv = ce && bus_i.wr && (bus_i.addr == SANC_ADV_OFS);
	assign wr_istat = ce && bus_i.wr && (bus_i.addr == SANC_ISTAT_OFS);
	assign wr_imask = ce && bus_i.wr && (bus_i.addr == SANC_IMASK_OFS);
	assign done_clr = wr_stat && !bus_i.wdata[SANC_STAT_DONE_BIT];
	assign an_evt = ce && partner_i.done;

	// ==========================================
	// Control shadow and applied copy
	logic [SANC_CTRL_W-1:0] pend_r;
	logic [SANC_CTRL_W-1:0] pend_nxt;
	logic [SANC_CTRL_W-1:0] appl_r;
	logic [1:0] wmode;

	assign wmode = bus_i.wdata[SANC_CTRL_MODE_HI:SANC_CTRL_MODE_LO];

	always_comb
	begin
		pend_nxt = bus_i.wdata[SANC_CTRL_W-1:0];
		// Reserved codes are refused so the applied mode is always legal
		if (wmode != SANC_MODE_SERDES && wmode != SANC_MODE_SGMII)
		begin
			pend_nxt[SANC_CTRL_MODE_HI:SANC_CTRL_MODE_LO] = pend_r[SANC_CTRL_MODE_HI:SANC_CTRL_MODE_LO];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			pend_r <= SANC_CTRL_RST;
		end
		else if (wr_ctrl)
		begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			appl_r <= SANC_CTRL_RST;
		end
		else if (wr_adv)
		begin
			appl_r <= pend_r;
		end
	end

	assign cfg_o.phy_side = appl_r[SANC_CTRL_ROLE_BIT];
	assign cfg_o.link_cfg = appl_r[SANC_CTRL_LINKCFG_BIT];
	assign cfg_o.mode = appl_r[SANC_CTRL_MODE_HI:SANC_CTRL_MODE_LO];
	assign cfg_o.irq_en = appl_r[SANC_CTRL_IEN_BIT];
	assign sgmii_appl = (appl_r[SANC_CTRL_MODE_HI:SANC_CTRL_MODE_LO] == SANC_MODE_SGMII);

	// ==========================================
	// Partner results
	logic link_r;
	logic [1:0] speed_r;
	logic fdx_r;
	logic done_r;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			link_r <= 1'b0;
			speed_r <= SANC_SPD_RST;
			fdx_r <= 1'b0;
		end
		else if (an_evt)
		begin
			if (sgmii_appl)
			begin
				link_r <= partner_i.link;
				speed_r <= partner_i.speed;
				fdx_r <= partner_i.full_dx;
			end
			else
			begin
				link_r <= 1'b0;
				speed_r <= SANC_SPD_RST;
				fdx_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			done_r <= 1'b0;
		end
		else if (an_evt)
		begin
			done_r <= 1'b1;
		end
		else if (done_clr)
		begin
			done_r <= 1'b0;
		end
	end

	// ==========================================
	// Event status and mask
	logic [SANC_IRQ_W-1:0] ev;
	logic [SANC_IRQ_W-1:0] istat_r;
	logic [SANC_IRQ_W-1:0] imask_r;

	assign ev[SANC_IRQ_LINK_BIT] = an_evt && sgmii_appl && (partner_i.link != link_r);
	assign ev[SANC_IRQ_SPD_BIT] = an_evt && sgmii_appl && (partner_i.speed == SANC_SPD_RSVD);

	genvar gi;
	generate
		for (gi = 0; gi < SANC_IRQ_W; gi++)
		begin : g_istat
			// Event in the clearing cycle is kept
			always_ff @(posedge clock)
			begin
				if (!rst_b)
				begin
					istat_r[gi] <= 1'b0;
				end
				else if (ev[gi])
				begin
					istat_r[gi] <= 1'b1;
				end
				else if (wr_istat && bus_i.wdata[gi])
				begin
					istat_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			imask_r <= SANC_IRQ_RST;
		end
		else if (wr_imask)
		begin
			imask_r <= bus_i.wdata[SANC_IRQ_W-1:0];
		end
	end

	assign irq_o = (done_r && appl_r[SANC_CTRL_IEN_BIT]) || (|(istat_r & imask_r));

	// ==========================================
	// Read port
	logic [SANC_DW-1:0] rd_val;

	always_comb
	begin
		rd_val = SANC_RD_ZERO;
		unique case (bus_i.addr)
			SANC_CTRL_OFS:
			begin
				rd_val[SANC_CTRL_W-1:0] = pend_r;
			end
			SANC_STAT_OFS:
			begin
				rd_val[SANC_STAT_LINK_BIT] = link_r;
				rd_val[SANC_STAT_SPD_HI:SANC_STAT_SPD_LO] = speed_r;
				rd_val[SANC_STAT_FDX_BIT] = fdx_r;
				rd_val[SANC_STAT_DONE_BIT] = done_r;
			end
			SANC_ISTAT_OFS:
			begin
				rd_val[SANC_IRQ_W-1:0] = istat_r;
			end
			SANC_IMASK_OFS:
			begin
				rd_val[SANC_IRQ_W-1:0] = imask_r;
			end
			default:
			begin
				rd_val = SANC_RD_ZERO;
			end
		endcase
	end

	// Data in the cycle after an enabled strobe, zero after other enabled cycles, held while ce is low
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			rdata_o <= SANC_RD_ZERO;
		end
		else if (ce)
		begin
			rdata_o <= bus_i.rd ? rd_val : SANC_RD_ZERO;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	property p_hold_pend;
		!wr_adv |=> $stable(appl_r);
	endproperty
	a_hold_pend: assert property (p_hold_pend) else $error("applied control moved without commit");

	property p_commit;
		wr_adv |=> (appl_r == $past(pend_r));
	endproperty
	a_commit: assert property (p_commit) else $error("commit did not copy shadow");

	property p_mode_legal;
		(cfg_o.mode == SANC_MODE_SGMII) || (cfg_o.mode == SANC_MODE_SERDES);
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("applied mode is reserved");

	property p_role_follows;
		wr_ctrl ##1 wr_adv |=> (cfg_o.phy_side == $past(bus_i.wdata[SANC_CTRL_ROLE_BIT], 2));
	endproperty
	a_role_follows: assert property (p_role_follows) else $error("role not applied");

	property p_capture;
		(an_evt && sgmii_appl) |=> (link_r == $past(partner_i.link)) && (speed_r == $past(partner_i.speed))
			&& (fdx_r == $past(partner_i.full_dx));
	endproperty
	a_capture: assert property (p_capture) else $error("partner results not captured");

	property p_serdes_empty;
		(an_evt && !sgmii_appl) |=> !link_r && (speed_r == SANC_SPD_RST) && !fdx_r;
	endproperty
	a_serdes_empty: assert property (p_serdes_empty) else $error("SerDes results leaked into status");

	property p_done_set;
		an_evt |=> done_r;
	endproperty
	a_done_set: assert property (p_done_set) else $error("completion flag not set");

	property p_done_sticky;
		(done_r && !done_clr) |=> done_r;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("completion flag dropped");

	property p_done_clear;
		(done_clr && !an_evt) |=> !done_r;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("completion flag not cleared");

	property p_irq_on;
		(done_r && cfg_o.irq_en) |-> irq_o;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

	property p_irq_off;
		(!cfg_o.irq_en && !(|(istat_r & imask_r))) |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

	property p_rd_stat;
		(ce && bus_i.rd && bus_i.addr == SANC_STAT_OFS && !an_evt && !done_clr)
			|=> (rdata_o[SANC_STAT_DONE_BIT] == done_r) && (rdata_o[SANC_STAT_LINK_BIT] == link_r);
	endproperty
	a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");

	property p_rd_idle;
		(ce && !bus_i.rd) |=> (rdata_o == SANC_RD_ZERO);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

	property p_ctrl_read;
		(ce && bus_i.rd && (bus_i.addr == SANC_CTRL_OFS)) |=> (rdata_o[SANC_CTRL_W-1:0] == $past(pend_r));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read not shadow");

	property p_ce_hold;
		!ce |=> $stable(appl_r) && $stable(done_r);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");

	property p_spd_event;
		ev[SANC_IRQ_SPD_BIT] |=> istat_r[SANC_IRQ_SPD_BIT];
	endproperty
	a_spd_event: assert property (p_spd_event) else $error("reserved speed event lost");

endmodule : sanc_regs

`default_nettype wire

// file: tb/sanc_partner_model.sv
// Behavioural link partner that announces negotiation results
`timescale 1ns/1ps
`default_nettype none
module sanc_partner_model
	import sanc_pkg::*;
(
	input wire logic clock,
	input wire logic start,
	input wire logic [2:0] lat,
	input wire logic [3:0] res,
	output sanc_partner_s p_o,
	output logic busy
);
	// ==========================================
	// Delay and completion pulse
	logic [3:0] cnt_r = 4'h0;
	logic [3:0] hold_r = 4'h0;
	logic done_w;
	always_ff @(posedge clock)
	begin
		if (start)
		begin
			cnt_r <= {1'b0, lat} + 4'h1;
			hold_r <= res;
		end
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
	assign busy = (cnt_r != 4'h0);
	assign done_w = (cnt_r == 4'h1);
	// Fields are junk outside the pulse
	assign p_o = {done_w, done_w ? hold_r : ~hold_r};
endmodule : sanc_partner_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top
	import sanc_pkg::*;
;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	sanc_bus_req_s bus = '0;
	sanc_partner_s prt;
	logic [15:0] rdata;
	sanc_cfg_s cfg;
	logic irq;
	logic start = 1'b0;
	logic [2:0] lat = 3'h0;
	logic [3:0] res = 4'h0;
	logic busy;
	int miscompares = 0;
	int checks = 0;
	int seed = 32'hd18b_c712;
	logic [15:0] d;
	logic [4:0] v;
	logic [4:0] old;
	logic [3:0] r;

	sanc_regs uut (.clock(clock), .rst_b(rst_b), .ce(ce), .bus_i(bus), .rdata_o(rdata), .partner_i(prt),
		.cfg_o(cfg), .irq_o(irq));
	sanc_partner_model pm (.clock(clock), .start(start), .lat(lat), .res(res), .p_o(prt), .busy(busy));

	initial forever #20 clock = ~clock;

	// ==========================================
	// Helpers
	function automatic logic [15:0] exp_stat(input logic [3:0] f, input logic dn);
		return {11'h000, f, dn};
	endfunction : exp_stat

	task wr(input logic [20:0] a, input logic [15:0] w);
		@(posedge clock);
		bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr

	task rd(input logic [20:0] a, output logic [15:0] q);
		@(posedge clock);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		q = rdata;
	endtask : rd

	// Control write then commit back to back, no gap between strobes
	task apply(input logic [4:0] c);
		@(posedge clock);
		bus <= '{addr: SANC_CTRL_OFS, wdata: {11'h000, c}, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus <= '{addr: SANC_ADV_OFS, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
		#1;
	endtask : apply

	task negotiate(input logic [3:0] f);
		@(posedge clock);
		start <= 1'b1;
		lat <= 3'($random(seed));
		res <= f;
		@(posedge clock);
		start <= 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clock);
			#1;
			if (!busy)
				break;
		end
	endtask : negotiate

	task finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (4000) @(posedge clock);
		miscompares++;
		finish_test();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		`CHK("cfg", SANC_CTRL_RST, cfg)
		`CHK("irq", 1'b0, irq)
		rd(SANC_CTRL_OFS, d);
		`CHK("ctrl", 16'h0004, d)
		rd(SANC_STAT_OFS, d);
		`CHK("stat", 16'h0000, d)
		rd(21'h1f_8003, d);
		`CHK("unmapped", 16'h0000, d)
		@(posedge clock);
		#1;
		`CHK("rdata idle", 16'h0000, rdata)
		old = SANC_CTRL_RST;
		for (int k = 0; k < 6; k++)
		begin
			v = 5'($random(seed));
			v[2:1] = k[0] ? SANC_MODE_SGMII : SANC_MODE_SERDES;
			if (!k[0])
				v[4:3] = 2'b11;
			wr(SANC_CTRL_OFS, {11'h000, v});
			rd(SANC_CTRL_OFS, d);
			`CHK("shadow", {11'h000, v}, d)
			`CHK("held", old, cfg)
			wr(SANC_ADV_OFS, 16'h0000);
			#1;
			`CHK("applied", v, cfg)
			old = v;
		end
		for (int m = 1; m < 4; m += 2)
		begin
			wr(SANC_CTRL_OFS, {11'h000, old[4:3], 2'(m), old[0]});
			rd(SANC_CTRL_OFS, d);
			`CHK("rsvd mode", {11'h000, old}, d)
		end
		apply(5'h1c);
		for (int k = 0; k < 8; k++)
		begin
			r = 4'($random(seed));
			if (r[2:1] == 2'b11)
				r[2:1] = 2'b10;
			negotiate(r);
			`CHK("irq off", 1'b0, irq)
			wr(SANC_STAT_OFS, 16'($random(seed)) | 16'h0001);
			rd(SANC_STAT_OFS, d);
			`CHK("result", exp_stat(r, 1'b1), d)
			wr(SANC_STAT_OFS, 16'h0000);
			rd(SANC_STAT_OFS, d);
			`CHK("cleared", exp_stat(r, 1'b0), d)
		end
		wr(SANC_ISTAT_OFS, 16'h0003);
		wr(SANC_IMASK_OFS, 16'h0001);
		rd(SANC_ISTAT_OFS, d);
		`CHK("ev clr", 16'h0000, d)
		r = {~r[3], 3'b101};
		negotiate(r);
		`CHK("ev irq", 1'b1, irq)
		wr(SANC_IMASK_OFS, 16'h0000);
		#1;
		`CHK("masked", 1'b0, irq)
		wr(SANC_ISTAT_OFS, 16'h0001);
		negotiate({r[3], 3'b110});
		rd(SANC_ISTAT_OFS, d);
		`CHK("rsvd speed", 16'h0002, d)
		wr(SANC_ISTAT_OFS, 16'h0002);
		wr(SANC_STAT_OFS, 16'h0000);
		apply(5'h1d);
		negotiate(4'hb);
		`CHK("irq on", 1'b1, irq)
		apply(5'h1c);
		`CHK("irq gated", 1'b0, irq)
		rd(SANC_STAT_OFS, d);
		`CHK("flag kept", exp_stat(4'hb, 1'b1), d)
		apply(5'h1d);
		`CHK("irq back", 1'b1, irq)
		wr(SANC_STAT_OFS, 16'h0000);
		#1;
		`CHK("irq drop", 1'b0, irq)
		apply(5'h19);
		negotiate(4'hf);
		rd(SANC_STAT_OFS, d);
		`CHK("serdes", 16'h0001, d)
		`CHK("irq serdes", 1'b1, irq)
		@(posedge clock);
		ce <= 1'b0;
		apply(5'h02);
		@(posedge clock);
		ce <= 1'b1;
		#1;
		`CHK("ce cfg", 5'h19, cfg)
		rd(SANC_CTRL_OFS, d);
		`CHK("ce ctrl", 16'h0019, d)
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		`CHK("cfg rst", SANC_CTRL_RST, cfg)
		`CHK("irq rst", 1'b0, irq)
		rd(SANC_STAT_OFS, d);
		`CHK("stat rst", 16'h0000, d)
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
